// >>> pkg/pctm_pkg.sv
package pctm_pkg;

    // ----------------------------------------------------------------
    // strap patterns, ordered {decode_enable_n, bit3, bit2, bit1, bit0}
    // ----------------------------------------------------------------
    localparam int STRAP_W = 5;
    localparam logic [4:0] XOR_PATTERN = 5'h00;
    localparam logic [4:0] TRI_PATTERN = 5'h05;

    // ----------------------------------------------------------------
    // sizes of the tested set, clock observation and analog controls
    // ----------------------------------------------------------------
    localparam int TESTED_PINS = 174;
    localparam int VIEW_CLOCKS = 4;
    localparam int REG_CTRL_W = 3;

    // ----------------------------------------------------------------
    // values held after reset
    // ----------------------------------------------------------------
    localparam logic RST_OE = 1'h0;
    localparam logic RST_OUT = 1'h0;
    localparam logic RST_FLASH_SEL_N = 1'h1;

    typedef enum logic [1:0] {
        mode_normal,
        mode_xor,
        mode_tri
    } pctm_mode_t;

endpackage : pctm_pkg

// >>> hw/pctm_xor_chain.sv
`timescale 1ns/1ps

// cascaded two-input stages, one distinct pin added per stage
module pctm_xor_chain #(
    parameter int WIDTH = pctm_pkg::TESTED_PINS
) (
    input wire logic [WIDTH-1:0] i_pins,
    output logic o_result
);

    // ----------------------------------------------------------------
    // chain
    // ----------------------------------------------------------------
    logic [WIDTH-1:0] stage;

    assign stage[0] = i_pins[0];

    genvar g;
    generate
        for (g = 1; g < WIDTH; g++) begin : g_stage
            assign stage[g] = stage[g-1] ^ i_pins[g];
        end
        if (WIDTH < 2) begin : g_bad_width
            $error("xor chain needs at least two pins");
        end
    endgenerate

    assign o_result = stage[WIDTH-1];

endmodule : pctm_xor_chain

// >>> hw/pctm_test_modes.sv
// Overview of operation
// - all five straps low selects xor continuity mode
// - decode enable low, select bits 0101 selects tristate mode
// - xor mode floats the drivers of every tested pin
// - xor mode drives flash select pin with the final tree stage
// - xor mode treats every tested pin as an input
// - tree output is xor of all tested pins, one pin per stage
// - tested set: bus, eeprom, flash, leds, sw pins, media pins
// - scan port, straps, analog, crystal, test, regulator pins excluded
// - tristate mode floats all digital outputs except scan data out
// - tristate mode leaves analog outputs untouched
// - float instruction from scan controller also floats outputs
// - scan reset is active low; low clears the float instruction
// - clock observation pin drives an internal clock picked by setting
// - factory test input is active low, idle high
`timescale 1ns/1ps

module pctm_test_modes #(
    parameter int TREE_W = pctm_pkg::TESTED_PINS,
    parameter int NCLK = pctm_pkg::VIEW_CLOCKS
) (
    input wire logic i_clock,
    input wire logic i_nrst,
    input wire logic i_clk_en,
    input wire logic i_mode_decode_enable_n,
    input wire logic i_mode_select_bit3,
    input wire logic i_mode_select_bit2,
    input wire logic i_clk_view_pin_in,
    input wire logic i_mode_select_bit0_pin_in,
    input wire logic i_float_outputs_instruction,
    input wire logic i_scan_reset_n,
    input wire logic i_factory_test_n,
    input wire logic [TREE_W-1:0] i_tested_pin_in,
    input wire logic [TREE_W-1:0] i_core_pin_out,
    input wire logic [TREE_W-1:0] i_core_pin_oe,
    output logic [TREE_W-1:0] o_pin_out,
    output logic [TREE_W-1:0] o_pin_oe,
    input wire logic i_core_flash_select_n,
    output logic o_flash_select_out_n,
    output logic o_flash_select_oe,
    input wire logic i_core_bit0_out,
    input wire logic i_core_bit0_oe,
    output logic o_mode_select_bit0_pin_out,
    output logic o_mode_select_bit0_pin_oe,
    input wire logic [NCLK-1:0] i_int_clocks,
    input wire logic [$clog2(NCLK)-1:0] i_clk_view_sel,
    input wire logic i_clk_view_en,
    output logic o_clk_view_out,
    output logic o_clk_view_oe,
    input wire logic i_scan_data_out,
    input wire logic i_scan_data_oe,
    output logic o_scan_data_out,
    output logic o_scan_data_oe,
    input wire logic [pctm_pkg::REG_CTRL_W-1:0] i_reg_ctrl,
    output logic [pctm_pkg::REG_CTRL_W-1:0] o_reg_ctrl,
    output logic o_xor_mode,
    output logic o_float_mode,
    output logic o_factory_test_active
);

    // ----------------------------------------------------------------
    // elaboration checks
    // ----------------------------------------------------------------
    generate
        if (TREE_W < 2) begin : g_bad_tree
            $error("tree width must be at least two");
        end
        if (NCLK < 2) begin : g_bad_nclk
            $error("clock observation needs at least two clocks");
        end
    endgenerate

    // ----------------------------------------------------------------
    // strap decode
    // ----------------------------------------------------------------
    function automatic pctm_pkg::pctm_mode_t decode_straps(
        input logic [pctm_pkg::STRAP_W-1:0] straps
    );
        pctm_pkg::pctm_mode_t m;
        m = pctm_pkg::mode_normal;
        if (straps == pctm_pkg::XOR_PATTERN) begin
            m = pctm_pkg::mode_xor;
        end else if (straps == pctm_pkg::TRI_PATTERN) begin
            m = pctm_pkg::mode_tri;
        end
        return m;
    endfunction : decode_straps

    // bit1 shares the clock observation pin, bit0 a software pin
    wire logic [pctm_pkg::STRAP_W-1:0] straps = {
        i_mode_decode_enable_n, i_mode_select_bit3, i_mode_select_bit2,
        i_clk_view_pin_in, i_mode_select_bit0_pin_in};

    pctm_pkg::pctm_mode_t mode_ff;
    pctm_pkg::pctm_mode_t nxt_mode;
    assign nxt_mode = decode_straps(straps);

    // ----------------------------------------------------------------
    // float instruction and factory test
    // ----------------------------------------------------------------
    logic float_ff;
    logic nxt_float;
    // scan reset low empties the instruction, so it gates the float
    assign nxt_float = i_float_outputs_instruction & i_scan_reset_n;

    logic factory_ff;
    logic nxt_factory;
    assign nxt_factory = ~i_factory_test_n;

    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            mode_ff <= pctm_pkg::mode_normal;
            float_ff <= 1'h0;
            factory_ff <= 1'h0;
        end else if (i_clk_en) begin
            mode_ff <= nxt_mode;
            float_ff <= nxt_float;
            factory_ff <= nxt_factory;
        end
    end

    // ----------------------------------------------------------------
    // pin driver control
    // ----------------------------------------------------------------
    wire logic is_xor = (mode_ff == pctm_pkg::mode_xor);
    // float instruction wins over xor: fixture asked for all floated
    wire logic is_float = (mode_ff == pctm_pkg::mode_tri) | float_ff;
    wire logic any_test = is_xor | is_float;

    wire logic tree_out;
    pctm_xor_chain #(
        .WIDTH(TREE_W)
    ) u_chain (
        .i_pins(i_tested_pin_in),
        .o_result(tree_out)
    );

    // tested pins: floated in both test modes, normal otherwise
    wire logic [TREE_W-1:0] nxt_pin_oe =
        any_test ? '0 : i_core_pin_oe;
    wire logic [TREE_W-1:0] nxt_pin_out = i_core_pin_out;

    // flash select carries the tree result in xor mode only
    wire logic nxt_flash_oe = is_float ? 1'h0 : 1'h1;
    wire logic nxt_flash_n = (is_xor & ~float_ff) ? tree_out
                                                  : i_core_flash_select_n;

    // strap pins stay undriven in test modes so the decode holds
    wire logic nxt_bit0_oe = any_test ? 1'h0 : i_core_bit0_oe;
    wire logic nxt_view_oe = any_test ? 1'h0 : i_clk_view_en;

    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            o_pin_oe <= '0;
            o_pin_out <= '0;
            o_flash_select_oe <= pctm_pkg::RST_OE;
            o_flash_select_out_n <= pctm_pkg::RST_FLASH_SEL_N;
            o_mode_select_bit0_pin_oe <= pctm_pkg::RST_OE;
            o_mode_select_bit0_pin_out <= pctm_pkg::RST_OUT;
            o_clk_view_oe <= pctm_pkg::RST_OE;
        end else if (i_clk_en) begin
            o_pin_oe <= nxt_pin_oe;
            o_pin_out <= nxt_pin_out;
            o_flash_select_oe <= nxt_flash_oe;
            o_flash_select_out_n <= nxt_flash_n;
            o_mode_select_bit0_pin_oe <= nxt_bit0_oe;
            o_mode_select_bit0_pin_out <= i_core_bit0_out;
            o_clk_view_oe <= nxt_view_oe;
        end
    end

    // ----------------------------------------------------------------
    // scan data out, analog controls and status
    // ----------------------------------------------------------------
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            o_scan_data_oe <= pctm_pkg::RST_OE;
            o_scan_data_out <= pctm_pkg::RST_OUT;
            o_reg_ctrl <= '0;
            o_xor_mode <= 1'h0;
            o_float_mode <= 1'h0;
            o_factory_test_active <= 1'h0;
        end else if (i_clk_en) begin
            o_scan_data_oe <= i_scan_data_oe;
            o_scan_data_out <= i_scan_data_out;
            o_reg_ctrl <= i_reg_ctrl;
            o_xor_mode <= is_xor & ~float_ff;
            o_float_mode <= is_float;
            o_factory_test_active <= factory_ff;
        end
    end

    // ----------------------------------------------------------------
    // clock observation
    // ----------------------------------------------------------------
    // a clock cannot pass a flop at its own rate, so this stays a mux
    wire logic sel_ok = (32'(i_clk_view_sel) < NCLK);
    assign o_clk_view_out = sel_ok ? i_int_clocks[i_clk_view_sel]
                                   : 1'h0;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (!i_nrst);

    xor_decode_a: assert property (
        i_clk_en && straps == 5'h00 |=> mode_ff == pctm_pkg::mode_xor)
        else $error("xor strap pattern not decoded");

    tri_decode_a: assert property (
        i_clk_en && straps == 5'h05 |=> mode_ff == pctm_pkg::mode_tri)
        else $error("tristate strap pattern not decoded");

    xor_float_a: assert property (
        i_clk_en && mode_ff == pctm_pkg::mode_xor |=> o_pin_oe == '0)
        else $error("tested pin driven in xor mode");

    xor_out_a: assert property (
        i_clk_en && mode_ff == pctm_pkg::mode_xor && !float_ff
        |=> o_flash_select_oe
            && o_flash_select_out_n == $past(^i_tested_pin_in))
        else $error("flash select does not carry tree result");

    xor_input_a: assert property (
        i_clk_en && is_xor && !float_ff && (|i_core_pin_oe)
        |=> o_pin_oe == '0
            && o_flash_select_out_n == $past(^i_tested_pin_in))
        else $error("tested pin left driving in xor mode");

    xor_parity_a: assert property (
        (i_clk_en && is_xor && !float_ff) [*2]
        |=> (o_flash_select_out_n != $past(o_flash_select_out_n))
            == ((^$past(i_tested_pin_in)) != (^$past(i_tested_pin_in, 2))))
        else $error("tree output change does not follow parity");

    strap_free_a: assert property (
        i_clk_en && any_test
        |=> !o_mode_select_bit0_pin_oe && !o_clk_view_oe)
        else $error("strap pin driven during test mode");

    tri_float_a: assert property (
        i_clk_en && is_float
        |=> o_pin_oe == '0 && !o_flash_select_oe
            && o_scan_data_oe == $past(i_scan_data_oe))
        else $error("digital output driven in tristate mode");

    analog_pass_a: assert property (
        i_clk_en |=> o_reg_ctrl == $past(i_reg_ctrl))
        else $error("analog control disturbed");

    float_instr_a: assert property (
        i_clk_en && i_float_outputs_instruction && i_scan_reset_n
        ##1 i_clk_en |=> o_pin_oe == '0 && o_float_mode)
        else $error("float instruction did not float outputs");

    scan_reset_a: assert property (
        i_clk_en && !i_scan_reset_n |=> !float_ff)
        else $error("float instruction kept under scan reset");

    clk_view_a: assert property (
        i_clk_en && i_clk_view_en && !any_test
        |=> o_clk_view_oe
            && o_clk_view_out == (sel_ok && i_int_clocks[i_clk_view_sel]))
        else $error("clock observation not driven");

    factory_flag_a: assert property (
        i_clk_en && !i_factory_test_n ##1 i_clk_en
        |=> o_factory_test_active)
        else $error("factory test not reported");

    normal_pass_a: assert property (
        i_clk_en && !any_test
        |=> o_pin_oe == $past(i_core_pin_oe)
            && o_pin_out == $past(i_core_pin_out)
            && o_flash_select_out_n == $past(i_core_flash_select_n))
        else $error("normal pin function disturbed");

    clk_freeze_a: assert property (
        !i_clk_en |=> $stable(o_pin_oe) && $stable(o_flash_select_out_n))
        else $error("state changed while clock enable low");

    bit0_pass_a: assert property (
        i_clk_en && !any_test
        |=> o_mode_select_bit0_pin_oe == $past(i_core_bit0_oe)
            && o_mode_select_bit0_pin_out == $past(i_core_bit0_out))
        else $error("software pin normal drive disturbed");

    float_wins_a: assert property (
        i_clk_en && float_ff
        |=> !o_flash_select_oe && !o_xor_mode && o_float_mode)
        else $error("float instruction did not override xor mode");

    scan_keep_a: assert property (
        i_clk_en |=> o_scan_data_out == $past(i_scan_data_out))
        else $error("scan data out not kept running");

    xor_mode_c: cover property (
        i_clk_en && straps == 5'h00 ##2 o_xor_mode);
    tri_mode_c: cover property (
        i_clk_en && straps == 5'h05 ##2 o_float_mode);
    float_instr_c: cover property (
        i_clk_en && i_float_outputs_instruction && !any_test
        ##2 o_float_mode);
    xor_toggle_c: cover property (
        o_xor_mode && $changed(o_flash_select_out_n));
    clk_freeze_c: cover property (
        !i_clk_en ##1 !i_clk_en);

endmodule : pctm_test_modes

// >>> testbench/pctm_fixture_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// test fixture: drives straps and probes the tested pins
// ----------------------------------------------------------------
module pctm_fixture_model #(
    parameter int W = 174
) (
    input wire logic [4:0] i_straps,
    input wire logic [W-1:0] i_drive,
    input wire logic [W-1:0] i_dev_out,
    input wire logic [W-1:0] i_dev_oe,
    output logic o_dec_n,
    output logic o_b3,
    output logic o_b2,
    output logic o_b1,
    output logic o_b0,
    output logic [W-1:0] o_pins
);
    assign {o_dec_n, o_b3, o_b2, o_b1, o_b0} = i_straps;
    // device drive wins; a probe only reaches a floated pin
    assign o_pins = (i_dev_oe & i_dev_out) | (~i_dev_oe & i_drive);
endmodule : pctm_fixture_model

// >>> testbench/tb_pin_continuity_test_modes.sv
`timescale 1ns/1ps
module tb_pin_continuity_test_modes;
    localparam int W = pctm_pkg::TESTED_PINS;
    logic clock = 1'b0;
    logic nrst = 1'b0;
    logic [4:0] straps = 5'h1F;
    logic [W-1:0] drive = '0;
    logic [W-1:0] core_out = '0;
    logic [W-1:0] core_oe = '0;
    logic fl_n = 1'b1, b0_out = 1'b0, b0_oe = 1'b0, fl_i = 1'b0;
    logic sc_rst_n = 1'b1, fact_n = 1'b1, sd_out = 1'b0, sd_oe = 1'b0;
    logic [3:0] clks = 4'h0;
    logic [1:0] sel = 2'h0;
    logic view_en = 1'b0;
    logic clk_en = 1'b1;
    logic [2:0] reg_in = 3'h0;
    wire dec_n, b3, b2, b1, b0;
    wire [W-1:0] pins, pin_out, pin_oe;
    wire fso_n, fso_oe, b0o, b0o_oe, cv, cv_oe, sdo, sdo_oe, xm, fm, fta;
    wire [2:0] reg_out;
    int mismatches = 0;
    int tests_run = 0;

    always #20 clock = ~clock;

    pctm_fixture_model #(.W(W)) fixture (.i_straps(straps),
        .i_drive(drive), .i_dev_out(pin_out), .i_dev_oe(pin_oe),
        .o_dec_n(dec_n), .o_b3(b3), .o_b2(b2), .o_b1(b1), .o_b0(b0),
        .o_pins(pins));

    pctm_test_modes dut (.i_clock(clock), .i_nrst(nrst), .i_clk_en(clk_en),
        .i_mode_decode_enable_n(dec_n), .i_mode_select_bit3(b3),
        .i_mode_select_bit2(b2), .i_clk_view_pin_in(b1),
        .i_mode_select_bit0_pin_in(b0), .i_float_outputs_instruction(fl_i),
        .i_scan_reset_n(sc_rst_n), .i_factory_test_n(fact_n),
        .i_tested_pin_in(pins), .i_core_pin_out(core_out),
        .i_core_pin_oe(core_oe), .o_pin_out(pin_out), .o_pin_oe(pin_oe),
        .i_core_flash_select_n(fl_n), .o_flash_select_out_n(fso_n),
        .o_flash_select_oe(fso_oe), .i_core_bit0_out(b0_out),
        .i_core_bit0_oe(b0_oe), .o_mode_select_bit0_pin_out(b0o),
        .o_mode_select_bit0_pin_oe(b0o_oe), .i_int_clocks(clks),
        .i_clk_view_sel(sel), .i_clk_view_en(view_en),
        .o_clk_view_out(cv), .o_clk_view_oe(cv_oe),
        .i_scan_data_out(sd_out), .i_scan_data_oe(sd_oe),
        .o_scan_data_out(sdo), .o_scan_data_oe(sdo_oe),
        .i_reg_ctrl(reg_in), .o_reg_ctrl(reg_out), .o_xor_mode(xm),
        .o_float_mode(fm), .o_factory_test_active(fta));

    task chk(input string what, input logic [W-1:0] seen,
            input logic [W-1:0] exp);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value %s exp %h seen %h", what, exp, seen);
        end
    endtask : chk

    // three edges covers the two-edge mode latency
    task settle;
        repeat (3) @(posedge clock);
        #1;
    endtask : settle

    task set_straps(input logic [4:0] s);
        @(posedge clock);
        straps <= s;
        settle();
    endtask : set_straps

    task test_normal;
        @(posedge clock);
        core_oe <= {W/2{2'b10}};
        core_out <= {W/2{2'b01}};
        {b0_out, b0_oe} <= 2'h3;
        foreach (straps[i]) begin
            set_straps(5'h1F ^ (5'h01 << i));
            chk("pin oe", pin_oe, {W/2{2'b10}});
            chk("pin out", pin_out, {W/2{2'b01}});
            chk("flash oe", fso_oe, 1'b1);
            chk("float", {xm, fm}, 2'b00);
            chk("bit0 pin", {b0o, b0o_oe}, 2'h3);
        end
        $display("normal test done");
    endtask : test_normal

    task test_xor;
        int k;
        @(posedge clock);
        core_oe <= '1;
        set_straps(5'h00);
        chk("pin oe", pin_oe, '0);
        chk("flash oe", fso_oe, 1'b1);
        chk("xor mode", xm, 1'b1);
        for (k = 0; k < W; k++) begin
            @(posedge clock);
            drive <= ~({W{1'b1}} << (k + 1));
            repeat (2) @(posedge clock);
            #1;
            chk("tree out", fso_n, W'((k + 1) % 2));
        end
        $display("xor test done");
    endtask : test_xor

    task test_tri;
        @(posedge clock);
        {sd_out, sd_oe, b0_oe, view_en} <= 4'hF;
        reg_in <= 3'h5;
        set_straps(5'h05);
        chk("pin oe", pin_oe, '0);
        chk("side oe", {fso_oe, b0o_oe, cv_oe}, 3'h0);
        chk("scan out", {sdo, sdo_oe}, 2'h3);
        chk("regulator", reg_out, 3'h5);
        chk("float", {xm, fm}, 2'b01);
        $display("tristate test done");
    endtask : test_tri

    task test_float;
        set_straps(5'h1F);
        @(posedge clock);
        fl_i <= 1'b1;
        settle();
        chk("pin oe", pin_oe, '0);
        chk("float", fm, 1'b1);
        chk("scan oe", sdo_oe, 1'b1);
        @(posedge clock);
        sc_rst_n <= 1'b0;
        settle();
        chk("float", fm, 1'b0);
        chk("pin oe", pin_oe, core_oe);
        @(posedge clock);
        {fl_i, sc_rst_n} <= 2'b01;
        $display("float test done");
    endtask : test_float

    task test_view;
        int s;
        for (s = 0; s < 8; s++) begin
            @(posedge clock);
            sel <= 2'(s);
            clks <= (s < 4) ? 4'h1 << s : ~(4'h1 << (s - 4));
            #1;
            chk("clock view", cv, W'(s < 4));
        end
        chk("view oe", cv_oe, 1'b1);
        $display("clock view test done");
    endtask : test_view

    task test_factory;
        @(posedge clock);
        fact_n <= 1'b0;
        settle();
        chk("factory", fta, 1'b1);
        @(posedge clock);
        fact_n <= 1'b1;
        settle();
        chk("factory", fta, 1'b0);
        $display("factory test done");
    endtask : test_factory

    // straps move to xor while frozen; nothing may follow until enabled
    task test_freeze;
        @(posedge clock);
        clk_en <= 1'b0;
        straps <= 5'h00;
        settle();
        chk("frozen oe", pin_oe, core_oe);
        chk("frozen mode", {xm, fm}, 2'b00);
        @(posedge clock);
        clk_en <= 1'b1;
        settle();
        chk("xor mode", xm, 1'b1);
        chk("pin oe", pin_oe, '0);
        set_straps(5'h1F);
        $display("freeze test done");
    endtask : test_freeze

    task close_out;
        $display("%0d checks, %0d mismatches", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : close_out

    // about 610 cycles expected; hang cut at about sixteen times that
    initial begin
        #400000;
        mismatches++;
        close_out();
    end

    initial begin
        repeat (16) @(posedge clock);
        #1;
        chk("reset oe", pin_oe, '0);
        chk("reset flash oe", fso_oe, 1'b0);
        chk("reset flash", fso_n, 1'b1);
        @(posedge clock);
        nrst <= 1'b1;
        test_normal();
        test_xor();
        test_tri();
        test_float();
        test_freeze();
        test_view();
        test_factory();
        close_out();
    end
endmodule : tb_pin_continuity_test_modes
